// ==== inc/ipc_pkg.sv ====
/*
 * Shared constants and types for the idle power command handler: register
 * byte offsets, taskfile command codes, the unload signature, status and
 * error bit positions, standby timeout figures and the timing base.
 * Assumes a 50 MHz APB clock and 32-bit APB data.
 */
package ipc_pkg;

    // ************************************************************
    // Timing base
    // ************************************************************
    localparam int unsigned CLK_PERIOD_NS = 20;
    localparam int unsigned SECOND_NS     = 1000000000;
    localparam int unsigned SEC_CYCLES    = SECOND_NS / CLK_PERIOD_NS;
    localparam int unsigned TICK_W        = 26;

    // ************************************************************
    // Register byte offsets
    // ************************************************************
    localparam logic [7:0] OFF_FEATURE  = 8'h00;
    localparam logic [7:0] OFF_SECCNT   = 8'h04;
    localparam logic [7:0] OFF_LBA_LOW  = 8'h08;
    localparam logic [7:0] OFF_LBA_MID  = 8'h0c;
    localparam logic [7:0] OFF_LBA_HIGH = 8'h10;
    localparam logic [7:0] OFF_COMMAND  = 8'h14;
    localparam logic [7:0] OFF_STATUS   = 8'h18;
    localparam logic [7:0] OFF_ERROR    = 8'h1c;
    localparam logic [7:0] OFF_POWER    = 8'h20;
    localparam logic [7:0] OFF_TIMEOUT  = 8'h24;
    localparam logic [7:0] OFF_INT_STAT = 8'h28;
    localparam logic [7:0] OFF_INT_CLR  = 8'h2c;
    localparam logic [7:0] OFF_INT_EN   = 8'h30;

    // ************************************************************
    // Command codes and unload signature
    // ************************************************************
    localparam logic [7:0] CMD_IDLE       = 8'he3;
    localparam logic [7:0] CMD_IDLE_ALT   = 8'h97;
    localparam logic [7:0] CMD_IDLE_IMM   = 8'he1;
    localparam logic [7:0] CMD_IMM_ALT    = 8'h95;
    localparam logic [7:0] UNL_FEATURE    = 8'h44;
    localparam logic [7:0] UNL_SECCNT     = 8'h00;
    localparam logic [7:0] UNL_LBA_LOW    = 8'h4c;
    localparam logic [7:0] UNL_LBA_MID    = 8'h4e;
    localparam logic [7:0] UNL_LBA_HIGH   = 8'h55;
    localparam logic [7:0] UNL_RESULT_LOW = 8'hc4;
    localparam logic [7:0] TF_RESET       = 8'h00;

    // ************************************************************
    // Status, error and interrupt bit positions
    // ************************************************************
    localparam int unsigned ST_BSY  = 7;
    localparam int unsigned ST_RDY  = 6;
    localparam int unsigned ST_DSC  = 4;
    localparam int unsigned ST_ERR  = 0;
    localparam int unsigned ER_ABT  = 2;
    localparam int unsigned IRQ_W   = 3;
    localparam int unsigned EV_DONE = 0;
    localparam int unsigned EV_ABRT = 1;
    localparam int unsigned EV_STBY = 2;

    // ************************************************************
    // Standby timeout codes and figures, in seconds
    // ************************************************************
    localparam logic [7:0]  TO_OFF        = 8'd0;
    localparam logic [7:0]  TO_LIN_MAX    = 8'd240;
    localparam logic [7:0]  TO_HALF_MAX   = 8'd251;
    localparam logic [7:0]  TO_21M        = 8'd252;
    localparam logic [7:0]  TO_8H         = 8'd253;
    localparam logic [7:0]  TO_RSVD       = 8'd254;
    localparam logic [14:0] TO_UNIT_SEC   = 15'd5;
    localparam logic [14:0] TO_HALF_SEC   = 15'd1800;
    localparam logic [14:0] TO_21M_SEC    = 15'd1260;
    localparam logic [14:0] TO_8H_SEC     = 15'd28800;
    localparam logic [14:0] TO_21M15S_SEC = 15'd1275;
    localparam int unsigned SEC_W         = 15;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic {
        PM_STANDBY,
        PM_IDLE
    } ipc_pm_t;

    typedef enum logic {
        EX_READY,
        EX_SPIN
    } ipc_ex_t;

endpackage : ipc_pkg

// ==== src/ipc_top.sv ====
/*
 * Idle power command handler: an APB slave holding a taskfile shadow that
 * executes the idle and idle immediate commands (with the unload variant),
 * keeps the automatic standby timer and raises a level interrupt.
 * Assumes all inputs are synchronous to pclk and that the spindle and cache
 * logic outside answer through spindle_at_speed and write_active.
 */
// Notes on behaviour
// - Idle codes E3h and 97h act alike
// - Standby plus idle: enter idle, load timer
// - Already idle: stay in present idle mode
// - Spin up on entry, skip if rotating
// - Idle keeps spindle on, commands served at once
// - Timeout zero disables auto standby
// - Codes 1-240 times five; 241-251 half hours
// - 252, 253, 255 fixed; 254 reserved
// - Interval elapsed without access: enter standby
// - Host access reloads full interval
// - Immediate codes E1h and 95h enter idle
// - Idle immediate keeps stored timeout
// - Unload signature; return C4h in LBA low
// - Unload parks heads at once
// - Unload aborts read look-ahead
// - Writing during unload: suspend flush, keep cache
// - Resets or other command resume flushing
`timescale 1ns/1ps
`default_nettype none

module ipc_top #(
    parameter int unsigned TICK_CYCLES = ipc_pkg::SEC_CYCLES
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        spindle_at_speed,
    input  wire logic        write_active,
    input  wire logic        host_access,
    input  wire logic        ata_soft_reset,
    input  wire logic        ata_hard_reset,
    output logic             spindle_on,
    output logic             spin_up_start,
    output logic             head_unload,
    output logic             lookahead_abort,
    output logic             flush_suspend,
    output logic             standby_mode,
    output logic             cmd_forward,
    output logic             irq
);

    // ************************************************************
    // Timeout decode
    // ************************************************************
    function automatic logic [ipc_pkg::SEC_W-1:0] timeout_secs(input logic [7:0] code);
        logic [ipc_pkg::SEC_W-1:0] c;
        c = {7'h00, code};
        if (code <= ipc_pkg::TO_LIN_MAX) begin
            timeout_secs = ipc_pkg::SEC_W'(c * ipc_pkg::TO_UNIT_SEC);
        end else if (code <= ipc_pkg::TO_HALF_MAX) begin
            timeout_secs = ipc_pkg::SEC_W'((c - {7'h00, ipc_pkg::TO_LIN_MAX})
                                           * ipc_pkg::TO_HALF_SEC);
        end else if (code == ipc_pkg::TO_21M) begin
            timeout_secs = ipc_pkg::TO_21M_SEC;
        end else if (code == ipc_pkg::TO_8H) begin
            timeout_secs = ipc_pkg::TO_8H_SEC;
        end else begin
            timeout_secs = ipc_pkg::TO_21M15S_SEC;
        end
    endfunction : timeout_secs

    // ************************************************************
    // Declarations
    // ************************************************************
    logic [7:0]                feature_reg;
    logic [7:0]                seccnt_reg;
    logic [7:0]                lba_low_reg;
    logic [7:0]                lba_mid_reg;
    logic [7:0]                lba_high_reg;
    logic [7:0]                command_reg;
    logic                      err_reg;
    logic                      abt_reg;
    logic [7:0]                timeout_code_reg;
    logic                      timer_en_reg;
    logic [ipc_pkg::SEC_W-1:0] interval_reg;
    logic [ipc_pkg::SEC_W-1:0] remain_reg;
    logic [ipc_pkg::TICK_W-1:0] tick_cnt_reg;
    logic [ipc_pkg::IRQ_W-1:0] int_stat_reg;
    logic [ipc_pkg::IRQ_W-1:0] int_en_reg;
    ipc_pkg::ipc_pm_t          pm_reg;
    ipc_pkg::ipc_ex_t          ex_reg;
    logic                      wr_acc;
    logic                      rd_setup;
    logic                      cmd_wr;
    logic [7:0]                cmd_code;
    logic                      is_idle;
    logic                      is_imm;
    logic                      is_unload;
    logic                      cmd_abort;
    logic                      cmd_enter;
    logic                      need_spin;
    logic                      spin_done;
    logic                      sec_tick;
    logic                      access;
    logic                      expire;
    logic [ipc_pkg::IRQ_W-1:0] events;
    logic [7:0]                status_val;
    logic [7:0]                error_val;
    logic                      addr_ok;
    logic [31:0]               rdata_next;

    // ************************************************************
    // APB handshake
    // ************************************************************
    assign pready   = 1'b1;
    assign wr_acc   = psel & penable & pwrite;
    assign rd_setup = psel & ~penable & ~pwrite;

    always_comb begin
        addr_ok    = 1'b1;
        rdata_next = 32'h0000_0000;
        if (paddr == ipc_pkg::OFF_FEATURE) begin
            rdata_next = {24'h00_0000, feature_reg};
        end else if (paddr == ipc_pkg::OFF_SECCNT) begin
            rdata_next = {24'h00_0000, seccnt_reg};
        end else if (paddr == ipc_pkg::OFF_LBA_LOW) begin
            rdata_next = {24'h00_0000, lba_low_reg};
        end else if (paddr == ipc_pkg::OFF_LBA_MID) begin
            rdata_next = {24'h00_0000, lba_mid_reg};
        end else if (paddr == ipc_pkg::OFF_LBA_HIGH) begin
            rdata_next = {24'h00_0000, lba_high_reg};
        end else if (paddr == ipc_pkg::OFF_COMMAND) begin
            rdata_next = {24'h00_0000, command_reg};
        end else if (paddr == ipc_pkg::OFF_STATUS) begin
            rdata_next = {24'h00_0000, status_val};
        end else if (paddr == ipc_pkg::OFF_ERROR) begin
            rdata_next = {24'h00_0000, error_val};
        end else if (paddr == ipc_pkg::OFF_POWER) begin
            rdata_next = {26'h000_0000, cmd_forward, flush_suspend, head_unload,
                          spindle_on, ex_reg == ipc_pkg::EX_SPIN, pm_reg == ipc_pkg::PM_IDLE};
        end else if (paddr == ipc_pkg::OFF_TIMEOUT) begin
            rdata_next = {timer_en_reg, remain_reg, 8'h00, timeout_code_reg};
        end else if (paddr == ipc_pkg::OFF_INT_STAT) begin
            rdata_next = {29'h0000_0000, int_stat_reg};
        end else if (paddr == ipc_pkg::OFF_INT_CLR) begin
            rdata_next = 32'h0000_0000;
        end else if (paddr == ipc_pkg::OFF_INT_EN) begin
            rdata_next = {29'h0000_0000, int_en_reg};
        end else begin
            addr_ok = 1'b0;
        end
    end

    // Read data is captured in the setup phase so it comes from a flop.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata <= rdata_next;
        end
    end

    assign pslverr = psel & penable & ~addr_ok;

    // ************************************************************
    // Taskfile shadow
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            feature_reg  <= ipc_pkg::TF_RESET;
            seccnt_reg   <= ipc_pkg::TF_RESET;
            lba_low_reg  <= ipc_pkg::TF_RESET;
            lba_mid_reg  <= ipc_pkg::TF_RESET;
            lba_high_reg <= ipc_pkg::TF_RESET;
            command_reg  <= ipc_pkg::TF_RESET;
        end else begin
            if (wr_acc && paddr == ipc_pkg::OFF_FEATURE) begin
                feature_reg <= pwdata[7:0];
            end
            if (wr_acc && paddr == ipc_pkg::OFF_SECCNT) begin
                seccnt_reg <= pwdata[7:0];
            end
            if (cmd_enter && is_unload) begin
                lba_low_reg <= ipc_pkg::UNL_RESULT_LOW;
            end else if (wr_acc && paddr == ipc_pkg::OFF_LBA_LOW) begin
                lba_low_reg <= pwdata[7:0];
            end
            if (wr_acc && paddr == ipc_pkg::OFF_LBA_MID) begin
                lba_mid_reg <= pwdata[7:0];
            end
            if (wr_acc && paddr == ipc_pkg::OFF_LBA_HIGH) begin
                lba_high_reg <= pwdata[7:0];
            end
            if (cmd_wr) begin
                command_reg <= pwdata[7:0];
            end
        end
    end

    // ************************************************************
    // Command decode
    // ************************************************************
    assign cmd_wr    = wr_acc && paddr == ipc_pkg::OFF_COMMAND;
    assign cmd_code  = pwdata[7:0];
    assign is_idle   = cmd_wr && (cmd_code == ipc_pkg::CMD_IDLE
                                  || cmd_code == ipc_pkg::CMD_IDLE_ALT);
    assign is_imm    = cmd_wr && (cmd_code == ipc_pkg::CMD_IDLE_IMM
                                  || cmd_code == ipc_pkg::CMD_IMM_ALT);
    assign is_unload = is_imm && feature_reg == ipc_pkg::UNL_FEATURE
                       && seccnt_reg == ipc_pkg::UNL_SECCNT
                       && lba_low_reg == ipc_pkg::UNL_LBA_LOW
                       && lba_mid_reg == ipc_pkg::UNL_LBA_MID
                       && lba_high_reg == ipc_pkg::UNL_LBA_HIGH;
    // An idle or idle immediate command landing during spin-up, or an idle command with a reserved timeout, cannot run.
    assign cmd_abort = (is_idle || is_imm)
                       && (ex_reg == ipc_pkg::EX_SPIN
                           || (is_idle && seccnt_reg == ipc_pkg::TO_RSVD));
    assign cmd_enter = (is_idle || is_imm) && !cmd_abort;
    assign need_spin = cmd_enter && !spindle_at_speed;
    assign spin_done = ex_reg == ipc_pkg::EX_SPIN && spindle_at_speed;

    // ************************************************************
    // Execution and power mode
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ex_reg <= ipc_pkg::EX_READY;
        end else begin
            case (ex_reg)
                ipc_pkg::EX_READY: begin
                    if (need_spin) begin
                        ex_reg <= ipc_pkg::EX_SPIN;
                    end
                end
                ipc_pkg::EX_SPIN: begin
                    if (spindle_at_speed) begin
                        ex_reg <= ipc_pkg::EX_READY;
                    end
                end
                default: ex_reg <= ipc_pkg::EX_READY;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pm_reg     <= ipc_pkg::PM_STANDBY;
            spindle_on <= 1'b0;
        end else if (cmd_enter) begin
            pm_reg     <= ipc_pkg::PM_IDLE;
            spindle_on <= 1'b1;
        end else if (expire) begin
            pm_reg     <= ipc_pkg::PM_STANDBY;
            spindle_on <= 1'b0;
        end
    end

    assign standby_mode = pm_reg == ipc_pkg::PM_STANDBY;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            spin_up_start   <= 1'b0;
            head_unload     <= 1'b0;
            lookahead_abort <= 1'b0;
            cmd_forward     <= 1'b0;
        end else begin
            spin_up_start   <= need_spin;
            head_unload     <= cmd_enter && is_unload;
            lookahead_abort <= cmd_enter && is_unload;
            cmd_forward     <= cmd_wr && !is_idle && !is_imm;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flush_suspend <= 1'b0;
        end else if (cmd_enter && is_unload) begin
            flush_suspend <= flush_suspend | write_active;
        end else if (ata_soft_reset || ata_hard_reset || cmd_wr) begin
            flush_suspend <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_reg <= 1'b0;
            abt_reg <= 1'b0;
        end else if (cmd_abort) begin
            err_reg <= 1'b1;
            abt_reg <= 1'b1;
        end else if (cmd_wr || ata_soft_reset || ata_hard_reset) begin
            err_reg <= 1'b0;
            abt_reg <= 1'b0;
        end
    end

    always_comb begin
        status_val                  = 8'h00;
        status_val[ipc_pkg::ST_BSY] = ex_reg == ipc_pkg::EX_SPIN;
        status_val[ipc_pkg::ST_RDY] = ex_reg == ipc_pkg::EX_READY;
        status_val[ipc_pkg::ST_DSC] = ex_reg == ipc_pkg::EX_READY;
        status_val[ipc_pkg::ST_ERR] = err_reg;
        error_val                   = 8'h00;
        error_val[ipc_pkg::ER_ABT]  = abt_reg;
    end

    // ************************************************************
    // Standby timer
    // ************************************************************
    // Any host access restarts the second prescaler too, so the reloaded
    // interval is never short by a partial second.
    assign access   = cmd_wr || host_access;
    assign sec_tick = tick_cnt_reg == ipc_pkg::TICK_W'(TICK_CYCLES - 1);
    assign expire   = pm_reg == ipc_pkg::PM_IDLE && ex_reg == ipc_pkg::EX_READY
                      && timer_en_reg && sec_tick && !access
                      && remain_reg == ipc_pkg::SEC_W'(1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_reg <= '0;
        end else if (access || sec_tick) begin
            tick_cnt_reg <= '0;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + ipc_pkg::TICK_W'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timeout_code_reg <= ipc_pkg::TO_OFF;
            timer_en_reg     <= 1'b0;
            interval_reg     <= '0;
        end else if (cmd_enter && is_idle) begin
            timeout_code_reg <= seccnt_reg;
            timer_en_reg     <= seccnt_reg != ipc_pkg::TO_OFF;
            interval_reg     <= timeout_secs(seccnt_reg);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            remain_reg <= '0;
        end else if (cmd_enter && is_idle) begin
            remain_reg <= timeout_secs(seccnt_reg);
        end else if (access) begin
            remain_reg <= interval_reg;
        end else if (pm_reg == ipc_pkg::PM_IDLE && timer_en_reg && sec_tick
                     && (remain_reg > ipc_pkg::SEC_W'(1)
                         || (remain_reg != '0 && ex_reg == ipc_pkg::EX_READY))) begin
            remain_reg <= remain_reg - ipc_pkg::SEC_W'(1);
        end
    end

    // ************************************************************
    // Interrupts
    // ************************************************************
    assign events[ipc_pkg::EV_DONE] = (cmd_enter && !need_spin) || spin_done;
    assign events[ipc_pkg::EV_ABRT] = cmd_abort;
    assign events[ipc_pkg::EV_STBY] = expire;

    // A hardware event in the same cycle as its clear keeps the bit set.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_stat_reg <= '0;
        end else if (wr_acc && paddr == ipc_pkg::OFF_INT_CLR) begin
            int_stat_reg <= (int_stat_reg & ~pwdata[ipc_pkg::IRQ_W-1:0]) | events;
        end else begin
            int_stat_reg <= int_stat_reg | events;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_en_reg <= '0;
        end else if (wr_acc && paddr == ipc_pkg::OFF_INT_EN) begin
            int_en_reg <= pwdata[ipc_pkg::IRQ_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |((int_stat_reg | events) & int_en_reg);
        end
    end

endmodule : ipc_top

`default_nettype wire

// ==== verif/ipc_top_chk.sv ====
/* Port-level assertions for ipc_top, bound to every instance below.
   Assumes the single pclk domain and the active-low presetn. */
`timescale 1ns/1ps
`default_nettype none
module ipc_top_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic spindle_at_speed,
    input wire logic host_access,
    input wire logic ata_soft_reset,
    input wire logic ata_hard_reset,
    input wire logic spindle_on,
    input wire logic spin_up_start,
    input wire logic head_unload,
    input wire logic lookahead_abort,
    input wire logic flush_suspend,
    input wire logic standby_mode,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic cmd_forward
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_SPINUP: assert property ($rose(spindle_on) |-> spin_up_start == !$past(spindle_at_speed))
        else $error("spin-up request wrong on idle entry");
    AST_IDLE_SPIN: assert property (!standby_mode |-> spindle_on)
        else $error("spindle off while idle");
    AST_HOLD_TMR: assert property (host_access && !standby_mode |=> !standby_mode)
        else $error("standby right after host access");
    AST_UNL_ONCE: assert property (head_unload |=> !head_unload)
        else $error("head unload pulse too long");
    AST_UNL_LA: assert property (head_unload |-> lookahead_abort)
        else $error("look-ahead not aborted on unload");
    AST_FLUSH_SET: assert property ($rose(flush_suspend) |-> head_unload)
        else $error("flush suspended without unload");
    AST_FLUSH_OFF: assert property (ata_soft_reset || ata_hard_reset |=> !flush_suspend)
        else $error("flush not resumed after reset");
    AST_STBY_OFF: assert property ($rose(standby_mode) |-> !spindle_on)
        else $error("spindle left on in standby");
    AST_FWD_CMD: assert property (
        psel && penable && pwrite && paddr == 8'h14 && pwdata[7:0] == 8'hc8 |=> cmd_forward)
        else $error("other command not forwarded");
endmodule : ipc_top_chk
bind ipc_top ipc_top_chk u_chk (.pclk, .presetn, .spindle_at_speed, .host_access,
    .ata_soft_reset, .ata_hard_reset, .spindle_on, .spin_up_start, .head_unload,
    .lookahead_abort, .flush_suspend, .standby_mode, .psel, .penable, .pwrite,
    .paddr, .pwdata, .cmd_forward);
`default_nettype wire

// ==== verif/ipc_spindle_model.sv ====
/* Spindle on the far side of ipc_top: at speed DLY cycles after spindle_on
   rises, stopped one cycle after it falls. Assumes the pclk domain. */
`timescale 1ns/1ps
`default_nettype none
module ipc_spindle_model #(
    parameter int DLY = 5
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic spindle_on,
    output logic      spindle_at_speed
);
    int cnt_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= 0;
        end else begin
            cnt_reg <= !spindle_on ? 0 : (cnt_reg < DLY) ? cnt_reg + 1 : cnt_reg;
        end
    end
    assign spindle_at_speed = (cnt_reg == DLY);
endmodule : ipc_spindle_model
`default_nettype wire

// ==== verif/tb_ipc_top.sv ====
/* Self-checking bench for ipc_top: APB tasks and command sequences.
   Assumes the spindle model as far side and a 4-cycle second. */
`timescale 1ns/1ps
`default_nettype none
module tb_ipc_top;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, se;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;
    logic        spindle_at_speed, write_active, host_access, ata_soft_reset, ata_hard_reset;
    logic        spindle_on, spin_up_start, head_unload, lookahead_abort, flush_suspend;
    logic        standby_mode, cmd_forward, irq;
    int          err_total, n_tests, n;
    logic [7:0]  uv[5] = '{8'h44, 8'h00, 8'h4c, 8'h4e, 8'h55};
    logic [7:0]  tc[7] = '{8'h00, 8'hf0, 8'hf1, 8'hfb, 8'hfc, 8'hfd, 8'hff};
    logic [14:0] ts[7] = '{15'h0, 15'h4b0, 15'h708, 15'h4d58, 15'h4ec, 15'h7080, 15'h4fb};
    ipc_top #(.TICK_CYCLES(4)) u_ipc_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .spindle_at_speed, .write_active, .host_access,
        .ata_soft_reset, .ata_hard_reset, .spindle_on, .spin_up_start, .head_unload,
        .lookahead_abort, .flush_suspend, .standby_mode, .cmd_forward, .irq);
    ipc_spindle_model u_ipc_spindle_model (.pclk, .presetn, .spindle_on, .spindle_at_speed);
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    task automatic give_verdict;
        if (err_total == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : give_verdict
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED %0t got %h expected %h", $time, g, e);
        end
    endtask : cmp
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        se = pslverr;
        {psel, penable} <= 2'h0;
        @(posedge pclk);
    endtask : apb
    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        cmp(q & m, e);
    endtask : rdc
    task automatic unload;
        for (int i = 0; i < 5; i++) apb(1'b1, 8'(4 * i), {24'h0, uv[i]});
        apb(1'b1, 8'h14, 32'he1);
    endtask : unload
    initial begin
        #400000;
        err_total++;
        give_verdict();
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {write_active, host_access, ata_soft_reset, ata_hard_reset} = 4'h0;
        err_total = 0;
        n_tests = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        cmp(standby_mode, 32'h1);
        apb(1'b1, 8'h30, 32'h7);
        for (int i = 0; i < 2; i++) begin
            apb(1'b1, 8'h04, 32'h1);
            apb(1'b1, 8'h14, i ? 32'h97 : 32'he3);
            cmp(standby_mode, 32'h0);
            for (n = 0; standby_mode !== 1'b1 && n < 200; n++) @(posedge pclk);
            cmp(n >= 17 && n <= 23, 32'h1);
        end
        rdc(8'h28, 32'h4, 32'h4);
        cmp(irq, 32'h1);
        apb(1'b1, 8'h30, 32'h0);
        @(posedge pclk);
        cmp(irq, 32'h0);
        apb(1'b1, 8'h30, 32'h7);
        apb(1'b1, 8'h2c, 32'h7);
        @(posedge pclk);
        cmp(irq, 32'h0);
        apb(1'b1, 8'h04, 32'hfe);
        apb(1'b1, 8'h14, 32'he3);
        rdc(8'h1c, 32'h4, 32'h4);
        rdc(8'h18, 32'h1, 32'h1);
        cmp(standby_mode, 32'h1);
        apb(1'b1, 8'h14, 32'he1);
        cmp(standby_mode, 32'h0);
        rdc(8'h1c, 32'h4, 32'h0);
        apb(1'b1, 8'h14, 32'he1);
        rdc(8'h1c, 32'h4, 32'h4);
        q = 32'h80;
        for (n = 0; q[7] !== 1'b0 && n < 40; n++) apb(1'b0, 8'h18, 32'h0);
        for (int i = 0; i < 7; i++) begin
            apb(1'b1, 8'h04, {24'h0, tc[i]});
            apb(1'b1, 8'h14, 32'he3);
            rdc(8'h24, i ? 32'hffff00ff : 32'h800000ff, {i != 0, ts[i], 8'h0, tc[i]});
            rdc(8'h18, 32'h80, 32'h0);
            cmp(standby_mode, 32'h0);
        end
        for (int i = 0; i < 2; i++) begin
            apb(1'b1, 8'h14, i ? 32'h95 : 32'he1);
            rdc(8'h24, 32'h800000ff, 32'h800000ff);
        end
        apb(1'b1, 8'h04, 32'h1);
        apb(1'b1, 8'h14, 32'he3);
        repeat (6) begin
            repeat (10) @(posedge pclk);
            host_access <= 1'b1;
            @(posedge pclk);
            host_access <= 1'b0;
        end
        cmp(standby_mode, 32'h0);
        apb(1'b1, 8'h04, 32'h0);
        apb(1'b1, 8'h14, 32'h97);
        repeat (60) @(posedge pclk);
        cmp(standby_mode, 32'h0);
        write_active <= 1'b1;
        for (int k = 0; k < 3; k++) begin
            unload();
            rdc(8'h08, 32'hff, 32'hc4);
            unload();
            cmp(flush_suspend, 32'h1);
            {ata_hard_reset, ata_soft_reset} <= 2'(1 << k);
            apb(k == 2, k == 2 ? 8'h14 : 8'h00, 32'hc8);
            {ata_hard_reset, ata_soft_reset} <= 2'h0;
            cmp(flush_suspend, 32'h0);
        end
        apb(1'b0, 8'hfc, 32'h0);
        cmp(se, 32'h1);
        give_verdict();
    end
endmodule : tb_ipc_top
`default_nettype wire
